// *** design/tmsr_regs.sv ***
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module tmsr_regs
	import tmsr_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire tmsr_bus_t           bus,
	output logic               [7:0] rdData_r,
	input  wire logic                rawValid,
	input  wire logic          [7:0] rawTemp,
	output logic                     adjValid_r,
	output logic               [7:0] adjTemp_r,
	input  wire tmsr_limits_t        limits,
	input  wire logic                firstThermalMode,
	input  wire logic                secondThermalMode,
	input  wire logic [TMSR_PINS-1:0] pinIrqRaw,
	output logic      [TMSR_PINS-1:0] pinIrq_r,
	output logic               [7:0] tempOffset_r
);

	logic [7:0] pinMask_r;
	logic [7:0] tempReading_r;
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] rd_nxt;
	logic       firstChange;
	logic       secondChange;
	logic       adjValidInt;
	logic [7:0] adjTempInt;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire logic wrMask   = bus.wr && bus.addr == TMSR_ADDR_PIN_MASK;
	wire logic wrOffset = bus.wr && bus.addr == TMSR_ADDR_TEMP_OFFSET;

	// Addresses that return register contents; all others read zero.
	wire logic rdMapped = bus.addr == TMSR_ADDR_TEMP_READING ||
		bus.addr == TMSR_ADDR_STATUS_ONE ||
		bus.addr == TMSR_ADDR_PIN_MASK ||
		bus.addr == TMSR_ADDR_TEMP_OFFSET;

	// Read mux; unmapped addresses read zero.
	always_comb begin
		unique case (bus.addr)
			TMSR_ADDR_TEMP_READING: rd_nxt = tempReading_r;
			TMSR_ADDR_STATUS_ONE:   rd_nxt = status_r;
			TMSR_ADDR_PIN_MASK:     rd_nxt = pinMask_r;
			TMSR_ADDR_TEMP_OFFSET:  rd_nxt = tempOffset_r;
			default:                rd_nxt = TMSR_RST_ZERO;
		endcase
	end

	// Read data only in the cycle after the strobe, zero otherwise.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) rdData_r <= TMSR_RST_ZERO;
		else     rdData_r <= bus.rd ? rd_nxt : TMSR_RST_ZERO;
	end

	// ------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pinMask_r    <= TMSR_RST_PIN_MASK;
			tempOffset_r <= TMSR_RST_ZERO;
		end else begin
			if (wrMask)   pinMask_r    <= bus.wdata;
			if (wrOffset) tempOffset_r <= bus.wdata;
		end
	end

	// ------------------------------------------------------------
	// Pin interrupt masking
	// ------------------------------------------------------------
	// Upper nibble of the mask gates pins twelve to fifteen.
	genvar g;
	generate
		for (g = 0; g < TMSR_PINS; g++) begin : gMask
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) pinIrq_r[g] <= 1'b0;
				else     pinIrq_r[g] <= pinIrqRaw[g] & ~pinMask_r[TMSR_MASK_LO+g];
			end

			// Each pin follows its raw request one cycle late unless its mask bit is set.
			AST_PIN_GATE: assert property (@(posedge sys_clk) disable iff (rst)
				1'b1 |=> pinIrq_r[g] == ($past(pinIrqRaw[g]) & ~$past(pinMask_r[TMSR_MASK_LO+g])))
				else $error("Pin interrupt gate wrong.");
		end
	endgenerate

	// ------------------------------------------------------------
	// Internal temperature path
	// ------------------------------------------------------------
	tmsr_temp_adjust uAdj (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.rawValid   (rawValid),
		.rawTemp    (rawTemp),
		.offset     (tempOffset_r),
		.adjValid_r (adjValidInt),
		.adjTemp_r  (adjTempInt)
	);

	// The adjusted value is exported so the limit comparators see the trimmed result.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tempReading_r <= TMSR_RST_ZERO;
			adjValid_r    <= 1'b0;
			adjTemp_r     <= TMSR_RST_ZERO;
		end else begin
			adjValid_r <= adjValidInt;
			adjTemp_r  <= adjTempInt;
			if (adjValidInt) tempReading_r <= adjTempInt;
		end
	end

	// ------------------------------------------------------------
	// Thermal mode events
	// ------------------------------------------------------------
	tmsr_edge_event uFirst (
		.sys_clk (sys_clk),
		.rst     (rst),
		.modeIn  (firstThermalMode),
		.change  (firstChange)
	);

	tmsr_edge_event uSecond (
		.sys_clk (sys_clk),
		.rst     (rst),
		.modeIn  (secondThermalMode),
		.change  (secondChange)
	);

	// ------------------------------------------------------------
	// Status one
	// ------------------------------------------------------------
	// Window flags follow each completed conversion cycle; a thermal
	// transition sets its bit once, and the next cycle's result replaces it.
	// Events win over a result arriving in the same clock.
	always_comb begin
		status_nxt = status_r;
		if (limits.done) begin
			status_nxt[TMSR_BIT_FIRST] = limits.firstOut;
			status_nxt[TMSR_BIT_SECOND] = limits.secondVoltMode ?
				limits.analogNineOut : limits.secondOut;
			status_nxt[TMSR_MASK_HI:TMSR_BIT_RAIL0] = limits.railOut;
		end
		if (firstChange)  status_nxt[TMSR_BIT_FIRST]  = 1'b1;
		if (secondChange) status_nxt[TMSR_BIT_SECOND] = 1'b1;
	end

	// Host writes never reach this register.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) status_r <= TMSR_RST_ZERO;
		else     status_r <= status_nxt;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence seqEngage;
		$rose(firstThermalMode);
	endsequence

	sequence seqDisengage;
		$fell(firstThermalMode);
	endsequence

	AST_MASK_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		pinMask_r[TMSR_MASK_HI] |=> !pinIrq_r[TMSR_PINS-1])
		else $error("Masked pin fifteen interrupt passed.");

	AST_OFFSET_RW: assert property (@(posedge sys_clk) disable iff (rst)
		wrOffset ##1 (bus.rd && bus.addr == TMSR_ADDR_TEMP_OFFSET)
		|=> rdData_r == $past(bus.wdata, 2))
		else $error("Offset readback mismatch.");

	AST_READING: assert property (@(posedge sys_clk) disable iff (rst)
		adjValidInt |=> tempReading_r == $past(adjTempInt))
		else $error("Temperature reading not updated.");

	AST_FIRST_WIN: assert property (@(posedge sys_clk) disable iff (rst)
		limits.done && !firstChange |=> status_r[TMSR_BIT_FIRST] == $past(limits.firstOut))
		else $error("First remote flag wrong.");

	AST_ENGAGE: assert property (@(posedge sys_clk) disable iff (rst)
		seqEngage |=> status_r[TMSR_BIT_FIRST])
		else $error("Engage event lost.");

	AST_DISENGAGE: assert property (@(posedge sys_clk) disable iff (rst)
		seqDisengage |=> status_r[TMSR_BIT_FIRST])
		else $error("Disengage event lost.");

	AST_SECOND_WIN: assert property (@(posedge sys_clk) disable iff (rst)
		limits.done && limits.secondVoltMode && !secondChange
		|=> status_r[TMSR_BIT_SECOND] == $past(limits.analogNineOut))
		else $error("Input nine flag wrong.");

	AST_SECOND_EVT: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(secondThermalMode) |=> status_r[TMSR_BIT_SECOND])
		else $error("Second channel thermal event lost.");

	AST_RAILS: assert property (@(posedge sys_clk) disable iff (rst)
		limits.done |=> status_r[TMSR_MASK_HI:TMSR_BIT_RAIL0] == $past(limits.railOut))
		else $error("Rail flags wrong.");

	AST_STATUS_RO: assert property (@(posedge sys_clk) disable iff (rst)
		!limits.done && !firstChange && !secondChange |=> $stable(status_r))
		else $error("Status changed without cause.");

	// ------------------------------------------------------------
	// Register access checks
	// ------------------------------------------------------------
	// A read strobe for one address, taken at a rising edge.
	sequence seqReadOf(logic [7:0] a);
		bus.rd && !bus.wr && bus.addr == a;
	endsequence

	// A write strobe for one address, taken at a rising edge.
	sequence seqWriteOf(logic [7:0] a);
		bus.wr && !bus.rd && bus.addr == a;
	endsequence

	// The data lines return to zero whenever no read was taken, so a stale
	// value can never be mistaken for a fresh answer.
	AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
		!bus.rd |=> rdData_r == TMSR_RST_ZERO)
		else $error("Read data not zero outside a read.");

	AST_RD_UNMAPPED: assert property (@(posedge sys_clk) disable iff (rst)
		bus.rd && !rdMapped |=> rdData_r == TMSR_RST_ZERO)
		else $error("Unmapped read returned data.");

	AST_RD_READING: assert property (@(posedge sys_clk) disable iff (rst)
		seqReadOf(TMSR_ADDR_TEMP_READING) |=> rdData_r == $past(tempReading_r))
		else $error("Temperature reading readback wrong.");

	AST_RD_STATUS: assert property (@(posedge sys_clk) disable iff (rst)
		seqReadOf(TMSR_ADDR_STATUS_ONE) |=> rdData_r == $past(status_r))
		else $error("Status readback wrong.");

	AST_RD_MASK: assert property (@(posedge sys_clk) disable iff (rst)
		seqReadOf(TMSR_ADDR_PIN_MASK) |=> rdData_r == $past(pinMask_r))
		else $error("Mask readback wrong.");

	AST_RD_OFFSET: assert property (@(posedge sys_clk) disable iff (rst)
		seqReadOf(TMSR_ADDR_TEMP_OFFSET) |=> rdData_r == $past(tempOffset_r))
		else $error("Offset register readback wrong.");

	AST_WR_MASK: assert property (@(posedge sys_clk) disable iff (rst)
		seqWriteOf(TMSR_ADDR_PIN_MASK) |=> pinMask_r == $past(bus.wdata))
		else $error("Mask write lost.");

	AST_WR_OFFSET: assert property (@(posedge sys_clk) disable iff (rst)
		seqWriteOf(TMSR_ADDR_TEMP_OFFSET) |=> tempOffset_r == $past(bus.wdata))
		else $error("Offset write lost.");

	// Writable registers change only on their own write strobe.
	AST_MASK_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!wrMask |=> $stable(pinMask_r))
		else $error("Mask changed without a write.");

	AST_OFFSET_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!wrOffset |=> $stable(tempOffset_r))
		else $error("Offset changed without a write.");

	// ------------------------------------------------------------
	// Temperature path checks
	// ------------------------------------------------------------
	AST_READING_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!adjValidInt |=> $stable(tempReading_r))
		else $error("Temperature reading changed without a result.");

	// The comparators must see the same trimmed value that the host reads.
	AST_ADJ_EXPORT: assert property (@(posedge sys_clk) disable iff (rst)
		adjValidInt |=> adjValid_r && adjTemp_r == $past(adjTempInt))
		else $error("Exported adjusted result wrong.");

	// ------------------------------------------------------------
	// Status event checks
	// ------------------------------------------------------------
	sequence seqEngageTwo;
		$rose(secondThermalMode);
	endsequence

	sequence seqDisengageTwo;
		$fell(secondThermalMode);
	endsequence

	// The change detectors fire exactly on a level change, never otherwise.
	AST_FIRST_CHANGE: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(firstThermalMode) |-> firstChange)
		else $error("First channel change not detected.");

	AST_FIRST_QUIET: assert property (@(posedge sys_clk) disable iff (rst)
		!$changed(firstThermalMode) |-> !firstChange)
		else $error("First channel false event.");

	AST_SECOND_CHANGE: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(secondThermalMode) |-> secondChange)
		else $error("Second channel change not detected.");

	AST_SECOND_QUIET: assert property (@(posedge sys_clk) disable iff (rst)
		!$changed(secondThermalMode) |-> !secondChange)
		else $error("Second channel false event.");

	AST_ENGAGE_TWO: assert property (@(posedge sys_clk) disable iff (rst)
		seqEngageTwo |=> status_r[TMSR_BIT_SECOND])
		else $error("Second channel engage lost.");

	AST_DISENGAGE_TWO: assert property (@(posedge sys_clk) disable iff (rst)
		seqDisengageTwo |=> status_r[TMSR_BIT_SECOND])
		else $error("Second channel disengage lost.");

	// An event and a result in the same clock: the event wins.
	AST_FIRST_EVT_WINS: assert property (@(posedge sys_clk) disable iff (rst)
		limits.done && firstChange |=> status_r[TMSR_BIT_FIRST])
		else $error("First event lost to a result.");

	AST_SECOND_EVT_WINS: assert property (@(posedge sys_clk) disable iff (rst)
		limits.done && secondChange |=> status_r[TMSR_BIT_SECOND])
		else $error("Second event lost to a result.");

	AST_SECOND_TEMP: assert property (@(posedge sys_clk) disable iff (rst)
		limits.done && !limits.secondVoltMode && !secondChange
		|=> status_r[TMSR_BIT_SECOND] == $past(limits.secondOut))
		else $error("Second remote flag wrong.");

	AST_FIRST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!limits.done && !firstChange |=> $stable(status_r[TMSR_BIT_FIRST]))
		else $error("First flag changed without cause.");

	AST_RAIL_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!limits.done |=> $stable(status_r[TMSR_MASK_HI:TMSR_BIT_RAIL0]))
		else $error("Rail flags changed without a result.");

endmodule

// *** design/tmsr_pkg.sv ***
// Functional notes
// - Mask bits 4..7 suppress pin 12..15 interrupts
// - Offset register holds signed eight-bit value
// - Offset added before storing and limit compare
// - Read-only register shows offset internal temperature
// - Bit 0 flags first remote out of window
// - Bit 0 pulses once on thermal engage
// - Bit 0 pulses once on thermal disengage
// - Bit 1 flags second remote or input nine
// - Bit 1 pulses on second channel thermal transitions
// - Bits 2..7 flag the six supply rails
package tmsr_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] TMSR_ADDR_TEMP_READING = 8'h1F;
	localparam logic [7:0] TMSR_ADDR_STATUS_ONE   = 8'h20;
	localparam logic [7:0] TMSR_ADDR_PIN_MASK     = 8'h40;
	localparam logic [7:0] TMSR_ADDR_TEMP_OFFSET  = 8'h41;

	localparam logic [7:0] TMSR_RST_ZERO      = 8'h00;
	localparam logic [7:0] TMSR_RST_PIN_MASK  = 8'h00;
	localparam int         TMSR_MASK_LO       = 4;
	localparam int         TMSR_MASK_HI       = 7;
	localparam int         TMSR_PINS          = 4;
	localparam int         TMSR_RAILS         = 6;
	localparam int         TMSR_BIT_RAIL0     = 2;
	localparam int         TMSR_BIT_SECOND    = 1;
	localparam int         TMSR_BIT_FIRST     = 0;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tmsr_bus_t;

	// One conversion cycle worth of limit outcomes.
	typedef struct packed {
		logic                  done;
		logic                  firstOut;
		logic                  secondOut;
		logic                  analogNineOut;
		logic                  secondVoltMode;
		logic [TMSR_RAILS-1:0] railOut;
	} tmsr_limits_t;

endpackage

// *** design/tmsr_temp_adjust.sv ***
`timescale 1ns/1ps
module tmsr_temp_adjust
	import tmsr_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       rawValid,
	input  wire logic [7:0] rawTemp,
	input  wire logic [7:0] offset,
	output logic            adjValid_r,
	output logic      [7:0] adjTemp_r
);

	// ------------------------------------------------------------
	// Offset sum
	// ------------------------------------------------------------
	// Two's complement add wraps; the offset is a calibration trim, so no saturation.
	wire logic [7:0] sum = 8'(rawTemp + offset);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			adjValid_r <= 1'b0;
			adjTemp_r  <= TMSR_RST_ZERO;
		end else begin
			adjValid_r <= rawValid;
			adjTemp_r  <= rawValid ? sum : adjTemp_r;
		end
	end

	AST_ADJ_SUM: assert property (@(posedge sys_clk) disable iff (rst)
		rawValid |=> adjValid_r && adjTemp_r == 8'($past(rawTemp) + $past(offset)))
		else $error("Adjusted temperature differs from raw plus offset.");

endmodule

// *** design/tmsr_edge_event.sv ***
`timescale 1ns/1ps
module tmsr_edge_event
	import tmsr_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic modeIn,
	output logic      change
);

	logic mode_r;

	// ------------------------------------------------------------
	// Transition detect
	// ------------------------------------------------------------
	// Both engage and disengage produce exactly one pulse.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) mode_r <= 1'b0;
		else     mode_r <= modeIn;
	end

	assign change = mode_r ^ modeIn;

endmodule

// *** sim/tmsr_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Register bus host
// ----------------------------------------
module tmsr_host_model
	import tmsr_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic [7:0] rdData_r,
	output tmsr_bus_t       bus
);
	// The bus idles with both strobes low until the first call.
	initial begin
		bus = '0;
	end
	// One-cycle write strobe beside address and data.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask
	// Write then read back with no idle cycle between the two strobes.
	task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] v);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 v = rdData_r;
	endtask
	// Data stands only in the cycle after the strobe, so it is taken just past that edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 v = rdData_r;
	endtask
endmodule

// *** sim/thermal_monitor_status_regs_tb_top.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Testbench
// ----------------------------------------
module thermal_monitor_status_regs_tb_top
	import tmsr_pkg::*;
();
	logic         sys_clk, rst, rawValid, adjValid_r, firstThermalMode, secondThermalMode;
	logic   [7:0] rawTemp, rdData_r, adjTemp_r, tempOffset_r, v;
	logic   [3:0] pinIrqRaw, pinIrq_r;
	tmsr_bus_t    bus;
	tmsr_limits_t limits, l;
	int           fails = 0, checked = 0;

	tmsr_host_model host (.sys_clk(sys_clk), .rdData_r(rdData_r), .bus(bus));
	tmsr_regs dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdData_r(rdData_r),
		.rawValid(rawValid), .rawTemp(rawTemp), .adjValid_r(adjValid_r),
		.adjTemp_r(adjTemp_r), .limits(limits), .firstThermalMode(firstThermalMode),
		.secondThermalMode(secondThermalMode), .pinIrqRaw(pinIrqRaw),
		.pinIrq_r(pinIrq_r), .tempOffset_r(tempOffset_r));

	// A 20 ns clock.
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// A hang anywhere counts as a mismatch.
	initial begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		close_out();
	end

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string n);
		host.rd(a, v);
		chk(n, v, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One conversion cycle ends with a single done pulse.
	task automatic conv(input tmsr_limits_t c);
		tmsr_limits_t p;
		p = c;
		p.done = 1'b1;
		@(posedge sys_clk);
		limits <= p;
		@(posedge sys_clk);
		limits.done <= 1'b0;
	endtask
	task automatic close_out;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence; each test after the reset reads mixes bus calls with direct drives of the raw, pin, limit and mode inputs.
	initial begin
		rst = 1'b1;
		rawValid = 1'b0;
		rawTemp = 8'h00;
		limits = '0;
		firstThermalMode = 1'b0;
		secondThermalMode = 1'b0;
		pinIrqRaw = 4'h0;
		tick(10);
		rst <= 1'b0;
		rdchk(TMSR_ADDR_TEMP_READING, 8'h00, "reading");
		rdchk(TMSR_ADDR_STATUS_ONE, 8'h00, "status");
		rdchk(TMSR_ADDR_TEMP_OFFSET, 8'h00, "offset");
		rdchk(TMSR_ADDR_PIN_MASK, TMSR_RST_PIN_MASK, "mask");
		$display("reset test done");
		host.wrrd(TMSR_ADDR_TEMP_OFFSET, 8'hFE, v);
		chk("offset back to back", v, 8'hFE);
		chk("offset port", tempOffset_r, 8'hFE);
		host.wr(TMSR_ADDR_TEMP_READING, 8'hFF);
		rdchk(TMSR_ADDR_TEMP_READING, 8'h00, "reading write");
		host.wr(TMSR_ADDR_STATUS_ONE, 8'hFF);
		rdchk(TMSR_ADDR_TEMP_OFFSET, 8'hFE, "offset");
		rdchk(TMSR_ADDR_STATUS_ONE, 8'h00, "status write");
		rdchk(8'h55, 8'h00, "unmapped");
		rawValid <= 1'b1;
		rawTemp <= 8'h30;
		tick(1);
		rawValid <= 1'b0;
		tick(1);
		#1 chk("adj valid", {7'h00, adjValid_r}, 8'h01);
		tick(1);
		#1 chk("adjusted", adjTemp_r, 8'h2E);
		rdchk(TMSR_ADDR_TEMP_READING, 8'h2E, "reading");
		$display("offset test done");
		host.wr(TMSR_ADDR_PIN_MASK, 8'hA0);
		pinIrqRaw <= 4'hF;
		tick(2);
		#1 chk("pin irq", {4'h0, pinIrq_r}, 8'h05);
		host.wr(TMSR_ADDR_PIN_MASK, 8'h0F);
		tick(2);
		#1 chk("pin irq", {4'h0, pinIrq_r}, 8'h0F);
		$display("mask test done");
		// Walk one out-of-window source at a time onto its bit.
		for (int i = 0; i < 9; i++) begin
			l = '0;
			l.firstOut = (i == 0);
			l.secondOut = (i == 1);
			l.secondVoltMode = (i == 2);
			l.analogNineOut = (i == 2);
			if (i > 2)
				l.railOut[i-3] = 1'b1;
			conv(l);
			rdchk(TMSR_ADDR_STATUS_ONE, (i < 2) ? 8'h01 << i : 8'h01 << (i - 1), "st");
		end
		conv('0);
		rdchk(TMSR_ADDR_STATUS_ONE, 8'h00, "status clear");
		// Thermal mode edges each leave one event until the next conversion.
		firstThermalMode <= 1'b1;
		tick(2);
		rdchk(TMSR_ADDR_STATUS_ONE, 8'h01, "engage one");
		conv('0);
		rdchk(TMSR_ADDR_STATUS_ONE, 8'h00, "after engage");
		firstThermalMode <= 1'b0;
		tick(2);
		rdchk(TMSR_ADDR_STATUS_ONE, 8'h01, "release one");
		secondThermalMode <= 1'b1;
		conv('0);
		tick(1);
		rdchk(TMSR_ADDR_STATUS_ONE, 8'h00, "held level");
		secondThermalMode <= 1'b0;
		tick(2);
		rdchk(TMSR_ADDR_STATUS_ONE, 8'h02, "release two");
		$display("status test done");
		close_out();
	end
endmodule
